// ==== wutc_pkg.sv ====
// Package: register map, field layout and timing constants of the wake-up timer control
package wutc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [9:0] OFF_PRESCALE = 10'h316;
  localparam logic [9:0] OFF_SLEEP_CFG = 10'h317;
  localparam logic [9:0] OFF_RELOAD_HI = 10'h318;
  localparam logic [9:0] OFF_RELOAD_LO = 10'h319;
  localparam logic [9:0] OFF_TMR_CTRL = 10'h31A;
  localparam logic [9:0] OFF_OSC_STAT = 10'h31B;
  localparam logic [9:0] OFF_IRQ_STAT = 10'h320;
  localparam logic [9:0] OFF_IRQ_MASK = 10'h321;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SLEEP_LSB = 3;
  localparam int SLEEP_MSB = 6;
  localparam int WAKE_EN_BIT = 0;
  localparam int FLAG_CLR_BIT = 0;
  localparam int CAL_EN_BIT = 1;
  localparam int ST_CAL_DONE_BIT = 5;
  localparam int ST_XTAL_BIT = 4;
  localparam int ST_POR_BIT = 2;
  localparam int ST_TO_BIT = 1;
  localparam int IRQ_TO_BIT = 0;
  localparam int IRQ_POR_BIT = 1;
  localparam int IRQ_CAL_BIT = 2;
  localparam int IRQ_XTAL_BIT = 3;
  // ----------------------------------------------------------------
  // Sleep setting codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SLEEP_KEEP_RETENTION_MEM = 4'h1;
  localparam logic [3:0] SLEEP_KEEP_CRYSTAL = 4'h4;
  localparam logic [3:0] SLEEP_KEEP_MEM_AND_CRYSTAL = 4'h5;
  localparam logic [3:0] SLEEP_KEEP_MEM_AND_RC_CLOCK = 4'hB;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [3:0] RST_IRQ = 4'h0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int CAL_TIME_NS = 1_000_000;
  // Least time: round up to whole cycles
  localparam int CAL_CYCLES =
    (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // RC calibration sequencer states
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_BUSY = 2'b01,
    CAL_DONE = 2'b10
  } wutc_cal_t;
endpackage : wutc_pkg

// ==== wutc_top.sv ====
// Wake-up timer control: sleep setup, reload, prescaler, calibration, flags
//
// Operation
// (RQ1) Sleep code selects retained memory and oscillators
// (RQ2) Wake-enable bit gates wake-up on expiry
// (RQ3) Reload is 16 bits, high then low
// (RQ4) High byte staged, commit on low write
// (RQ5) Software writes high byte first, write-only; the low byte here reads back the committed reload low byte
// (RQ6) Control bit 1 runs RC calibration
// (RQ7) Status bit 5 set after 1 ms
// (RQ8) Writing control bit 0 clears both flags
// (RQ9) Status bit 4 shows crystal settled
// (RQ10) Cold start flag sticky until cleared
// (RQ11) Timeout flag latches on expiry
// (RQ12) Prescaler divides by 1 to 65536
// (RQ13) Prescaler staged, effective on sleep write
// (RQ14) Timer counts prescaled ticks and reloads
`timescale 1ns/1ps
`default_nettype none
module wutc_top #(
  parameter int CAL_CYC = wutc_pkg::CAL_CYCLES
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Oscillator and power events
  input wire logic LF_TICK,
  input wire logic XTAL_SETTLED,
  input wire logic COLD_START,
  // Power control
  output logic KEEP_MEM,
  output logic KEEP_XTAL,
  output logic KEEP_RC,
  output logic RC_CAL_RUN,
  output logic WAKE_REQ,
  // Interrupt
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Terminal count of the prescaler for a given code
  function automatic logic [15:0] presc_term(input logic [2:0] code);
    unique case (code)
      3'h0: presc_term = 16'h0000;
      3'h1: presc_term = 16'h0003;
      3'h2: presc_term = 16'h0007;
      3'h3: presc_term = 16'h000F;
      3'h4: presc_term = 16'h007F;
      3'h5: presc_term = 16'h03FF;
      3'h6: presc_term = 16'h1FFF;
      3'h7: presc_term = 16'hFFFF;
    endcase
  endfunction : presc_term

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [2:0] presc_stage_r;
  logic [2:0] presc_act_r;
  logic [7:0] sleep_cfg_r;
  logic [7:0] reload_hi_r;
  logic [15:0] reload_r;
  logic [7:0] ctrl_r;
  logic [15:0] pre_cnt_r;
  logic [15:0] tmr_cnt_r;
  logic to_flag_r;
  logic por_flag_r;
  logic [14:0] cal_cnt_r;
  wutc_pkg::wutc_cal_t cal_st_r;
  wutc_pkg::wutc_cal_t cal_st_nxt;
  logic xtal_d_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_mask_r;
  logic [7:0] rdata_r;
  logic keep_mem_r;
  logic keep_xtal_r;
  logic keep_rc_r;
  logic cal_run_r;
  logic wake_r;
  logic irq_r;

  // One clock domain, so every check below shares this clock and reset
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Write strobes per register
  wire wr_presc = WR && (ADDR == wutc_pkg::OFF_PRESCALE);
  wire wr_sleep = WR && (ADDR == wutc_pkg::OFF_SLEEP_CFG);
  wire wr_hi = WR && (ADDR == wutc_pkg::OFF_RELOAD_HI);
  wire wr_lo = WR && (ADDR == wutc_pkg::OFF_RELOAD_LO);
  wire wr_ctrl = WR && (ADDR == wutc_pkg::OFF_TMR_CTRL);
  wire wr_istat = WR && (ADDR == wutc_pkg::OFF_IRQ_STAT);
  wire wr_imask = WR && (ADDR == wutc_pkg::OFF_IRQ_MASK);

  // Flag clear is a one-shot effect of the write itself
  wire flag_clr = wr_ctrl && WDATA[wutc_pkg::FLAG_CLR_BIT]; // RQ8

  wire [3:0] sleep_code =
    sleep_cfg_r[wutc_pkg::SLEEP_MSB:wutc_pkg::SLEEP_LSB];
  wire wake_en = sleep_cfg_r[wutc_pkg::WAKE_EN_BIT];
  wire cal_en = ctrl_r[wutc_pkg::CAL_EN_BIT];

  // Sleep code decode; reserved codes keep nothing alive
  wire dec_mem = (sleep_code == wutc_pkg::SLEEP_KEEP_RETENTION_MEM)
    || (sleep_code == wutc_pkg::SLEEP_KEEP_MEM_AND_CRYSTAL)
    || (sleep_code == wutc_pkg::SLEEP_KEEP_MEM_AND_RC_CLOCK); // RQ1
  wire dec_xtal = (sleep_code == wutc_pkg::SLEEP_KEEP_CRYSTAL)
    || (sleep_code == wutc_pkg::SLEEP_KEEP_MEM_AND_CRYSTAL); // RQ1
  wire dec_rc = sleep_code == wutc_pkg::SLEEP_KEEP_MEM_AND_RC_CLOCK; // RQ1

  // Keep outputs follow the written code two edges later
  chk_sleep_decode: assert property ( // RQ1
    wr_sleep |=> ##1
      ((KEEP_MEM == ($past(WDATA[6:3], 2) inside {4'h1, 4'h5, 4'hB}))
      && (KEEP_XTAL == ($past(WDATA[6:3], 2) inside {4'h4, 4'h5}))
      && (KEEP_RC == ($past(WDATA[6:3], 2) == 4'hB))))
    else $error("sleep code decode wrong");

  // Crystal status only meaningful in crystal sleep codes
  wire xtal_ok = XTAL_SETTLED && dec_xtal; // RQ9
  wire cal_done = (cal_st_r == wutc_pkg::CAL_DONE) && cal_en; // RQ7

  // Read-back of the crystal bit honours the sleep code gate
  chk_xtal_valid: assert property ( // RQ9
    RD && ADDR == wutc_pkg::OFF_OSC_STAT |=>
      RDATA[wutc_pkg::ST_XTAL_BIT] == ($past(XTAL_SETTLED)
      && ($past(sleep_code) inside {4'h4, 4'h5})))
    else $error("crystal status outside crystal codes");

  // ----------------------------------------------------------------
  // Timer datapath
  // ----------------------------------------------------------------
  wire [15:0] term = presc_term(presc_act_r); // RQ12
  wire tmr_tick = LF_TICK && (pre_cnt_r == term); // RQ12
  wire expire = tmr_tick && (tmr_cnt_r == 16'h0000); // RQ14

  // Interrupt events
  wire xtal_rise = xtal_ok && !xtal_d_r;
  wire cal_rise = (cal_st_nxt == wutc_pkg::CAL_DONE)
    && (cal_st_r != wutc_pkg::CAL_DONE);
  wire [3:0] ev = {xtal_rise, cal_rise, COLD_START, expire};

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] osc_stat;
  logic [7:0] rd_mux;
  always_comb begin
    osc_stat = 8'h00;
    osc_stat[wutc_pkg::ST_CAL_DONE_BIT] = cal_done; // RQ7
    osc_stat[wutc_pkg::ST_XTAL_BIT] = xtal_ok; // RQ9
    osc_stat[wutc_pkg::ST_POR_BIT] = por_flag_r; // RQ10
    osc_stat[wutc_pkg::ST_TO_BIT] = to_flag_r; // RQ11
  end

  // Staged and write-only registers read as zero
  always_comb begin
    unique case (ADDR)
      wutc_pkg::OFF_SLEEP_CFG: rd_mux = sleep_cfg_r;
      wutc_pkg::OFF_RELOAD_LO: rd_mux = reload_r[7:0];
      wutc_pkg::OFF_TMR_CTRL: rd_mux = ctrl_r;
      wutc_pkg::OFF_OSC_STAT: rd_mux = osc_stat;
      wutc_pkg::OFF_IRQ_STAT: rd_mux = {4'h0, irq_stat_r};
      wutc_pkg::OFF_IRQ_MASK: rd_mux = {4'h0, irq_mask_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Prescaler moves to the live copy only on a sleep write
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      presc_stage_r <= 3'h0;
      presc_act_r <= 3'h0;
      sleep_cfg_r <= wutc_pkg::RST_BYTE;
    end else begin
      if (wr_presc) presc_stage_r <= WDATA[2:0]; // RQ13
      if (wr_sleep) begin
        sleep_cfg_r <= WDATA;
        presc_act_r <= presc_stage_r; // RQ13
      end
    end
  end

  // Staged prescaler must not reach the counter before a sleep write
  chk_presc_stage: assert property ( // RQ13
    wr_presc && !wr_sleep |=> $stable(presc_act_r))
    else $error("prescaler took effect early");

  // High byte is staged so a half-written reload never runs
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      reload_hi_r <= wutc_pkg::RST_BYTE;
      reload_r <= wutc_pkg::RST_RELOAD;
    end else begin
      if (wr_hi) reload_hi_r <= WDATA; // RQ4
      if (wr_lo) reload_r <= {reload_hi_r, WDATA}; // RQ3 RQ4
    end
  end

  // Only the low-byte write moves the staged pair into the reload
  chk_reload_commit: assert property ( // RQ3
    wr_lo |=> reload_r == {$past(reload_hi_r), $past(WDATA)})
    else $error("reload not assembled from staged byte");
  chk_reload_stage: assert property ( // RQ4
    wr_hi && !wr_lo |=> $stable(reload_r))
    else $error("high byte took effect early");

  // Control register; bit 0 is also read back as written
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) ctrl_r <= wutc_pkg::RST_BYTE;
    else if (wr_ctrl) ctrl_r <= WDATA; // RQ6
  end

  // ----------------------------------------------------------------
  // Timer
  // ----------------------------------------------------------------
  // Low byte write restarts the count from the new reload
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pre_cnt_r <= 16'h0000;
      tmr_cnt_r <= wutc_pkg::RST_RELOAD;
    end else begin
      if (wr_sleep || tmr_tick) pre_cnt_r <= 16'h0000;
      else if (LF_TICK) pre_cnt_r <= pre_cnt_r + 16'h0001; // RQ12
      if (wr_lo) tmr_cnt_r <= {reload_hi_r, WDATA};
      else if (expire) tmr_cnt_r <= reload_r; // RQ14
      else if (tmr_tick) tmr_cnt_r <= tmr_cnt_r - 16'h0001; // RQ14
    end
  end

  // Prescaler wraps on each tick; expiry reloads the counter
  chk_presc_wrap: assert property ( // RQ12
    tmr_tick && !wr_sleep |=> pre_cnt_r == 16'h0000)
    else $error("prescaler not wrapped");
  chk_timer_reload: assert property ( // RQ14
    expire && !wr_lo |=> tmr_cnt_r == $past(reload_r))
    else $error("timer not reloaded on expiry");

  // ----------------------------------------------------------------
  // Event latches
  // ----------------------------------------------------------------
  // Set wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      to_flag_r <= 1'b0;
      por_flag_r <= 1'b0;
    end else begin
      to_flag_r <= expire || (to_flag_r && !flag_clr); // RQ11 RQ8
      por_flag_r <= COLD_START || (por_flag_r && !flag_clr); // RQ10 RQ8
    end
  end

  // Clear acts only when no new event lands in the same cycle
  chk_flag_clear: assert property ( // RQ8
    flag_clr && !expire && !COLD_START |=> !to_flag_r && !por_flag_r)
    else $error("flags not cleared");
  chk_por_hold: assert property ( // RQ10
    por_flag_r && !flag_clr |=> por_flag_r)
    else $error("cold start flag lost");
  chk_to_latch: assert property ( // RQ11
    expire |=> to_flag_r)
    else $error("timeout flag not set");

  // ----------------------------------------------------------------
  // RC calibration
  // ----------------------------------------------------------------
  // Dropping the enable aborts and forgets any result
  always_comb begin
    cal_st_nxt = cal_st_r;
    unique case (cal_st_r)
      wutc_pkg::CAL_IDLE:
        if (cal_en) cal_st_nxt = wutc_pkg::CAL_BUSY; // RQ6
      wutc_pkg::CAL_BUSY:
        if (!cal_en) cal_st_nxt = wutc_pkg::CAL_IDLE;
        else if (cal_cnt_r == 15'(CAL_CYC - 1))
          cal_st_nxt = wutc_pkg::CAL_DONE; // RQ7
      wutc_pkg::CAL_DONE:
        if (!cal_en) cal_st_nxt = wutc_pkg::CAL_IDLE;
      default: cal_st_nxt = wutc_pkg::CAL_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cal_st_r <= wutc_pkg::CAL_IDLE;
      cal_cnt_r <= 15'h0000;
    end else begin
      cal_st_r <= cal_st_nxt;
      if (cal_st_r == wutc_pkg::CAL_BUSY) cal_cnt_r <= cal_cnt_r + 15'h0001;
      else cal_cnt_r <= 15'h0000;
    end
  end

  // Run output drops with the enable; done only after the full count
  chk_cal_run: assert property ( // RQ6
    !cal_en |=> ##1 !RC_CAL_RUN)
    else $error("calibration runs while disabled");
  chk_cal_time: assert property ( // RQ7
    $rose(cal_done) |-> cal_en && $past(cal_cnt_r) == 15'(CAL_CYC - 1))
    else $error("calibration done at wrong time");

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Write one to clear; a new event in that cycle wins
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      irq_stat_r <= wutc_pkg::RST_IRQ;
      irq_mask_r <= wutc_pkg::RST_IRQ;
      xtal_d_r <= 1'b0;
    end else begin
      irq_stat_r <= ev | (irq_stat_r & ~(wr_istat ? WDATA[3:0] : 4'h0));
      if (wr_imask) irq_mask_r <= WDATA[3:0];
      xtal_d_r <= xtal_ok;
    end
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rdata_r <= 8'h00;
      keep_mem_r <= 1'b0;
      keep_xtal_r <= 1'b0;
      keep_rc_r <= 1'b0;
      cal_run_r <= 1'b0;
      wake_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      rdata_r <= RD ? rd_mux : 8'h00;
      keep_mem_r <= dec_mem; // RQ1
      keep_xtal_r <= dec_xtal; // RQ1
      keep_rc_r <= dec_rc; // RQ1
      cal_run_r <= cal_st_r == wutc_pkg::CAL_BUSY && cal_en; // RQ6
      wake_r <= expire && wake_en; // RQ2
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Wake pulse follows an expiry only when enabled
  chk_wake_gate: assert property ( // RQ2
    expire |=> (WAKE_REQ == $past(wake_en)))
    else $error("wake request not gated by enable");

  assign RDATA = rdata_r;
  assign KEEP_MEM = keep_mem_r;
  assign KEEP_XTAL = keep_xtal_r;
  assign KEEP_RC = keep_rc_r;
  assign RC_CAL_RUN = cal_run_r;
  assign WAKE_REQ = wake_r;
  assign IRQ = irq_r;

endmodule : wutc_top
`default_nettype wire

// ==== wakeup_timer_control_tb_top.sv ====
// Self-checking testbench of the wake-up timer control block
`timescale 1ns/1ps
`default_nettype none
module wakeup_timer_control_tb_top;
  // --------------------------------------------------------------
  // Stimulus, bookkeeping and the block
  // --------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic lf = 1'b0;
  logic xs = 1'b0;
  logic cs = 1'b0;
  logic rd_d = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic k_mem, k_xt, k_rc, cal_run, wake, irq;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int checks_done = 0;
  int wake_cnt = 0;
  integer seed = 59215;
  int divs[7] = '{1, 4, 8, 16, 128, 1024, 8192};

  // Free-running 20 MHz clock
  always #25 clk = ~clk;

  // Calibration count shortened so a run stays brief
  wutc_top #(.CAL_CYC(20)) wutc_top_inst (
    .SYS_CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wd), .WR(wr),
    .RD(rd), .RDATA(rdata), .LF_TICK(lf), .XTAL_SETTLED(xs),
    .COLD_START(cs), .KEEP_MEM(k_mem), .KEEP_XTAL(k_xt), .KEEP_RC(k_rc),
    .RC_CAL_RUN(cal_run), .WAKE_REQ(wake), .IRQ(irq));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // The note goes in before the strobe so the watcher always finds it
  task automatic rd_reg(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  // Random gaps between ticks so the prescaler sees uneven spacing
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      lf <= 1'b1;
      @(posedge clk);
      lf <= 1'b0;
      cyc($unsigned($random(seed)) % 3);
    end
  endtask : ticks

  task automatic cold_pulse;
    @(posedge clk);
    cs <= 1'b1;
    @(posedge clk);
    cs <= 1'b0;
  endtask : cold_pulse

  task automatic clr;
    wr_reg(wutc_pkg::OFF_TMR_CTRL, 8'h01);
    wr_reg(wutc_pkg::OFF_TMR_CTRL, 8'h00);
    wake_cnt = 0;
  endtask : clr

  task automatic cfg(input logic w);
    wr_reg(wutc_pkg::OFF_SLEEP_CFG,
           {1'b0, wutc_pkg::SLEEP_KEEP_MEM_AND_CRYSTAL, 2'b00, w});
  endtask : cfg

  task automatic arm(input logic [2:0] p, input logic [7:0] hi, lo,
                     input logic w);
    wr_reg(wutc_pkg::OFF_PRESCALE, {5'h00, p});
    cfg(w);
    wr_reg(wutc_pkg::OFF_RELOAD_HI, hi);
    wr_reg(wutc_pkg::OFF_RELOAD_LO, lo);
    clr;
  endtask : arm

  // One tick short of expiry nothing shows; the last tick fires
  task automatic run_exp(input int n, input logic w);
    ticks(n - 1);
    cyc(3);
    chk("wake count", 8'h00, 8'(wake_cnt));
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h00);
    ticks(1);
    cyc(3);
    chk("wake count", {7'h00, w}, 8'(wake_cnt));
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h02);
  endtask : run_exp

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // Watcher: read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d === 1'b1) chk("RDATA", exp_q.pop_front(), rdata);
    if (wake === 1'b1) wake_cnt++;
  end

  // Watchdog sized well above the longest tick run
  initial begin
    #3_000_000;
    fail_count++;
    tally_and_finish;
  end

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    cyc(20);
    rst <= 1'b0;
    @(negedge clk);
    chk("outputs", 8'h00, {2'b00, k_mem, k_xt, k_rc, cal_run, wake, irq});
    for (int a = 10'h316; a <= 10'h321; a++) rd_reg(10'(a), 8'h00);
    wr_reg(10'h3FF, 8'hFF);
    wr_reg(wutc_pkg::OFF_OSC_STAT, 8'hFF);
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h00);
    rd_reg(wutc_pkg::OFF_SLEEP_CFG, 8'h00);
    $display("Test reset values done");
    for (int c = 0; c < 16; c++) begin
      wr_reg(wutc_pkg::OFF_SLEEP_CFG, {1'b0, 4'(c), 3'b000});
      cyc(2);
      @(negedge clk);
      chk("keep", {5'h00, c == 1 || c == 5 || c == 11, c == 4 || c == 5,
          c == 11}, {5'h00, k_mem, k_xt, k_rc});
      rd_reg(wutc_pkg::OFF_SLEEP_CFG, {1'b0, 4'(c), 3'b000});
    end
    $display("Test sleep codes done");
    for (int i = 0; i < 7; i++) begin
      arm(3'(i), 8'h00, 8'h00, i != 2);
      run_exp(divs[i], i != 2);
    end
    arm(3'h7, 8'h00, 8'h00, 1'b1);
    ticks(64);
    cyc(3);
    chk("wake count", 8'h00, 8'(wake_cnt));
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h00);
    arm(3'h0, 8'h01, 8'h02, 1'b1);
    run_exp(259, 1'b1);
    rd_reg(wutc_pkg::OFF_RELOAD_LO, 8'h02);
    rd_reg(wutc_pkg::OFF_RELOAD_HI, 8'h00);
    wr_reg(wutc_pkg::OFF_RELOAD_LO, 8'h00);
    clr;
    run_exp(257, 1'b1);
    arm(3'h0, 8'h00, 8'h00, 1'b1);
    wr_reg(wutc_pkg::OFF_PRESCALE, 8'h01);
    clr;
    run_exp(1, 1'b1);
    cfg(1'b1);
    clr;
    run_exp(4, 1'b1);
    $display("Test timer done");
    cold_pulse;
    cyc(3);
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h06);
    wr_reg(wutc_pkg::OFF_TMR_CTRL, 8'h00);
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h06);
    clr;
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h00);
    $display("Test flags done");
    wr_reg(wutc_pkg::OFF_TMR_CTRL, 8'h02);
    cyc(2);
    @(negedge clk);
    chk("RC_CAL_RUN", 8'h01, {7'h00, cal_run});
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h00);
    cyc(25);
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h20);
    rd_reg(wutc_pkg::OFF_TMR_CTRL, 8'h02);
    wr_reg(wutc_pkg::OFF_TMR_CTRL, 8'h00);
    cyc(1);
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h00);
    $display("Test calibration done");
    wr_reg(wutc_pkg::OFF_SLEEP_CFG, 8'h20);
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h00);
    @(posedge clk);
    xs <= 1'b1;
    cyc(3);
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h10);
    wr_reg(wutc_pkg::OFF_SLEEP_CFG, 8'h08);
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h00);
    $display("Test crystal done");
    rd_reg(wutc_pkg::OFF_IRQ_STAT, 8'h0F);
    wr_reg(wutc_pkg::OFF_IRQ_STAT, 8'h0F);
    rd_reg(wutc_pkg::OFF_IRQ_STAT, 8'h00);
    wr_reg(wutc_pkg::OFF_IRQ_MASK, 8'h02);
    rd_reg(wutc_pkg::OFF_IRQ_MASK, 8'h02);
    cold_pulse;
    cyc(3);
    @(negedge clk);
    chk("IRQ", 8'h01, {7'h00, irq});
    rd_reg(wutc_pkg::OFF_IRQ_STAT, 8'h02);
    wr_reg(wutc_pkg::OFF_IRQ_MASK, 8'h00);
    cyc(2);
    @(negedge clk);
    chk("IRQ", 8'h00, {7'h00, irq});
    wr_reg(wutc_pkg::OFF_IRQ_MASK, 8'h02);
    cyc(2);
    @(negedge clk);
    chk("IRQ", 8'h01, {7'h00, irq});
    wr_reg(wutc_pkg::OFF_IRQ_STAT, 8'h02);
    cyc(2);
    @(negedge clk);
    chk("IRQ", 8'h00, {7'h00, irq});
    rd_reg(wutc_pkg::OFF_IRQ_STAT, 8'h00);
    cyc(3);
    $display("Test interrupts done");
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    @(negedge clk);
    chk("outputs", 8'h00, {2'b00, k_mem, k_xt, k_rc, cal_run, wake, irq});
    rd_reg(wutc_pkg::OFF_SLEEP_CFG, 8'h00);
    rd_reg(wutc_pkg::OFF_OSC_STAT, 8'h00);
    rd_reg(wutc_pkg::OFF_IRQ_MASK, 8'h00);
    cyc(3);
    $display("Test mid-run reset done");
    tally_and_finish;
  end
endmodule : wakeup_timer_control_tb_top
`default_nettype wire
